/* logic/dspm_defs.vh */
// Constants for the DRAM strobe, parity and address mux controller
`ifndef DSPM_DEFS_VH
`define DSPM_DEFS_VH

// Register byte offsets
`define DSPM_OFF_CONFIG      12'h000
`define DSPM_OFF_REFRESH     12'h004
`define DSPM_OFF_BASE0       12'h008
`define DSPM_OFF_BASE1       12'h00C
`define DSPM_OFF_CHECK       12'h010

// Reset values
`define DSPM_RST_CONFIG      16'h0000
`define DSPM_RST_REFRESH     16'h0000
`define DSPM_RST_BASE        16'h0000
`define DSPM_RST_CHECK       16'h0000

// Configuration register fields
`define DSPM_CFG_REF0        0
`define DSPM_CFG_REF1        1
`define DSPM_CFG_PAR0        8
`define DSPM_CFG_PAR1        9
`define DSPM_CFG_USER0       10
`define DSPM_CFG_USER1       11

// Base register fields
`define DSPM_BASE_EN         0
`define DSPM_BASE_MASK_LO    1
`define DSPM_BASE_MASK_HI    7
`define DSPM_BASE_ADDR_LO    9
`define DSPM_BASE_ADDR_HI    15

// Check control/status fields
`define DSPM_CHK_ODD         0
`define DSPM_CHK_ERR_LO      8
`define DSPM_CHK_ERR_HI      9
`define DSPM_CHK_WMASK       16'h0001

// Refresh interval field
`define DSPM_REF_FIELD_HI    7
`define DSPM_REFRESH_BASE    4096

// Cycle counts less one at 5 ns: tRCD 20, tCAS 15 plus 2 sync, tRAS 60, tRP 60
`define DSPM_ROW_LAST        8'h03
`define DSPM_CAS_LAST        8'h04
`define DSPM_RAS_LAST        8'h0B
`define DSPM_PRE_LAST        8'h0B

// Controller states
`define DSPM_ST_IDLE         3'h0
`define DSPM_ST_ROW          3'h1
`define DSPM_ST_COL          3'h2
`define DSPM_ST_CAS          3'h3
`define DSPM_ST_DONE         3'h4
`define DSPM_ST_RCAS         3'h5
`define DSPM_ST_RRAS         3'h6
`define DSPM_ST_PRE          3'h7

`endif

/* logic/dspm_parity.v */
// Per-byte parity generator for the 16-bit DRAM data path
`timescale 1ns/100ps
module dspm_parity (
   // Data and polarity
   input  wire [15:0] data,
   input  wire        odd,
   // Bit 1 upper byte, bit 0 lower byte
   output wire [1:0]  bits
);
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : byte_par
         assign bits[g] = (^data[8*g+7:8*g]) ^ odd;
      end
   endgenerate
endmodule

/* logic/dspm_ctrl.v */
// DRAM controller: bank strobes, address mux, byte parity and refresh
//
// Operation
// - First row strobe serves bank 0, second serves bank 1, both active low.
// - A bank's row strobe asserts for upper, lower and word accesses alike.
// - The bank hit is decided by each bank's programmed base and control.
// - Separate active-low write strobe goes low only in DRAM write cycles.
// - External master cycles leave the address bus undriven; mux output still toggles.
// - With parity enabled, writes generate and reads check the parity bits.
// - A parity mismatch on a read ends the processor cycle with a bus error.
// - First parity pin covers the upper byte, second covers the lower byte.
// - External master accesses get no parity generation or checking.
// - One fixed row/column mapping serves every bank size.
// - Outputs for A9..A16 carry row bits 9..16, then column bits 1..8.
// - A18, A20, A22 carry rows 18, 20, 22 then columns 17, 19, 21.
// - Config value 0x0501 enables refresh, parity and user access for bank 0.
// - Refresh register zero gives one refresh every 4096 clocks.
// - Bit 0 of a base register activates its bank; bits 7-1 hold the size mask, bits 15-9 the base.
// - Check status bits 9-8 report the parity result per bank.
// - First column strobe enables the upper byte, second the lower; both banks share.
// - Active-low error output asserts while any bank error bit is set.
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/100ps
`include "dspm_defs.vh"
module dspm_ctrl #(
   parameter REFRESH_BASE = `DSPM_REFRESH_BASE
) (
   // Clock, reset, enable
   input  wire        pclk,
   input  wire        presetn,
   input  wire        clk_en,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output reg         pslverr,
   // Processor and external master request
   input  wire        cpu_req,
   input  wire        cpu_write,
   input  wire        cpu_supervisor,
   input  wire        req_external,
   input  wire        cpu_upper,
   input  wire        cpu_lower,
   input  wire [23:1] cpu_addr,
   input  wire [15:0] cpu_wdata,
   output reg         cpu_ack,
   output reg         cpu_berr,
   output reg  [15:0] cpu_rdata,
   // DRAM strobes
   output reg         bank0_row_strobe_n,
   output reg         bank1_row_strobe_n,
   output reg         upper_byte_col_strobe_n,
   output reg         lower_byte_col_strobe_n,
   output reg         mem_write_strobe_n,
   output reg         row_col_select_out,
   // Muxed address pins
   output reg  [10:0] mem_addr_out,
   output reg         mem_addr_oe,
   // Data pins
   input  wire [15:0] mem_data_in,
   output reg  [15:0] mem_data_out,
   output reg         mem_data_oe,
   // Parity pins, bit 1 upper, bit 0 lower
   input  wire        upper_byte_check_bit_in,
   input  wire        lower_byte_check_bit_in,
   output reg         upper_byte_check_bit,
   output reg         lower_byte_check_bit,
   output reg         check_bits_oe,
   output wire        check_error_n
);
   // Registers
   reg [15:0] mem_config_reg;
   reg [15:0] refresh_interval_reg;
   reg [15:0] bank0_base_reg;
   reg [15:0] bank1_base_reg;
   reg [15:0] check_control_status_reg;
   wire [1:0] bank_check_error_flags;

   // Pin synchronisers
   reg [15:0] data_s1;
   reg [15:0] data_s2;
   reg [1:0]  chk_s1;
   reg [1:0]  chk_s2;

   // Cycle state
   reg [2:0]  state;
   reg [2:0]  next_state;
   reg [7:0]  timer;
   reg [7:0]  next_timer;
   reg [23:1] addr_l;
   reg        write_l;
   reg        ext_l;
   reg        upper_l;
   reg        lower_l;
   reg        bank1_l;
   reg        par_l;
   reg [15:0] wdata_l;
   reg        berr_l;
   reg        take_ref;
   reg        take_cpu;

   // Refresh timing
   reg [20:0] ref_count;
   reg        ref_pend;
   wire [20:0] ref_limit;
   wire        ref_wrap;
   wire        ref_any;

   // Bank decode
   wire [1:0]  hit;
   wire [15:0] base [0:1];
   wire [1:0]  user_ok;
   wire [1:0]  par_en;
   wire        req_user_ok;

   // Parity
   wire [1:0]  gen_bits;
   wire [1:0]  rd_bits;
   wire [1:0]  lane_en;
   wire        par_bad;
   wire [1:0]  err_set;

   // APB decode
   wire        apb_setup;
   wire        apb_wr;
   wire        off_ok;

   assign base[0] = bank0_base_reg;
   assign base[1] = bank1_base_reg;
   assign user_ok = {mem_config_reg[`DSPM_CFG_USER1], mem_config_reg[`DSPM_CFG_USER0]};
   assign par_en  = {mem_config_reg[`DSPM_CFG_PAR1], mem_config_reg[`DSPM_CFG_PAR0]};

   // Bank hit: enabled, and masked high address matches base
   genvar b;
   generate
      for (b = 0; b < 2; b = b + 1) begin : bank_dec
         assign hit[b] = base[b][`DSPM_BASE_EN] &
            (((cpu_addr[23:17] ^ base[b][`DSPM_BASE_ADDR_HI:`DSPM_BASE_ADDR_LO]) &
              base[b][`DSPM_BASE_MASK_HI:`DSPM_BASE_MASK_LO]) == 7'h00);
      end
   endgenerate

   assign req_user_ok = cpu_supervisor | (hit[0] ? user_ok[0] : user_ok[1]);

   // Refresh interval, zero field gives the base period
   assign ref_limit = REFRESH_BASE[20:0] *
      {13'h0000, refresh_interval_reg[`DSPM_REF_FIELD_HI:0]} + REFRESH_BASE[20:0];
   assign ref_wrap  = (ref_count == ref_limit - 21'h000001);
   assign ref_any   = mem_config_reg[`DSPM_CFG_REF0] | mem_config_reg[`DSPM_CFG_REF1];

   // Parity generate and check
   dspm_parity u_gen (
      .data (wdata_l),
      .odd  (check_control_status_reg[`DSPM_CHK_ODD]),
      .bits (gen_bits)
   );
   dspm_parity u_chk (
      .data (data_s2),
      .odd  (check_control_status_reg[`DSPM_CHK_ODD]),
      .bits (rd_bits)
   );
   assign lane_en = {upper_l, lower_l};
   assign par_bad = |((rd_bits ^ chk_s2) & lane_en);
   assign err_set = (state == `DSPM_ST_CAS && timer == 8'h00 && par_l && !write_l && par_bad) ?
                    {bank1_l, ~bank1_l} : 2'b00;
   assign bank_check_error_flags =
      check_control_status_reg[`DSPM_CHK_ERR_HI:`DSPM_CHK_ERR_LO];
   assign check_error_n = ~|bank_check_error_flags;

   // Next state
   always @* begin
      next_state = state;
      next_timer = (timer == 8'h00) ? 8'h00 : timer - 8'h01;
      take_ref = 1'b0;
      take_cpu = 1'b0;
      case (state)
         `DSPM_ST_IDLE: begin
            if (ref_pend && ref_any) begin
               take_ref = 1'b1;
               next_state = `DSPM_ST_RCAS;
               next_timer = `DSPM_CAS_LAST;
            end else if (cpu_req) begin
               take_cpu = 1'b1;
               if ((hit == 2'b00) || !req_user_ok) begin
                  next_state = `DSPM_ST_DONE;
               end else begin
                  next_state = `DSPM_ST_ROW;
                  next_timer = `DSPM_ROW_LAST;
               end
            end
         end
         `DSPM_ST_ROW: begin
            if (timer == 8'h00) begin
               next_state = `DSPM_ST_COL;
            end
         end
         `DSPM_ST_COL: begin
            next_state = `DSPM_ST_CAS;
            next_timer = `DSPM_CAS_LAST;
         end
         `DSPM_ST_CAS: begin
            if (timer == 8'h00) begin
               next_state = `DSPM_ST_DONE;
            end
         end
         `DSPM_ST_DONE: begin
            next_state = `DSPM_ST_PRE;
            next_timer = `DSPM_PRE_LAST;
         end
         `DSPM_ST_RCAS: begin
            if (timer == 8'h00) begin
               next_state = `DSPM_ST_RRAS;
               next_timer = `DSPM_RAS_LAST;
            end
         end
         `DSPM_ST_RRAS: begin
            if (timer == 8'h00) begin
               next_state = `DSPM_ST_PRE;
               next_timer = `DSPM_PRE_LAST;
            end
         end
         `DSPM_ST_PRE: begin
            if (timer == 8'h00) begin
               next_state = `DSPM_ST_IDLE;
            end
         end
         default: begin
            next_state = `DSPM_ST_IDLE;
         end
      endcase
   end

   // Synchronisers, refresh timer, cycle state
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_s1   <= 16'h0000;
         data_s2   <= 16'h0000;
         chk_s1    <= 2'b00;
         chk_s2    <= 2'b00;
         ref_count <= 21'h000000;
         ref_pend  <= 1'b0;
         state     <= `DSPM_ST_IDLE;
         timer     <= 8'h00;
         addr_l    <= 23'h000000;
         write_l   <= 1'b0;
         ext_l     <= 1'b0;
         upper_l   <= 1'b0;
         lower_l   <= 1'b0;
         bank1_l   <= 1'b0;
         par_l     <= 1'b0;
         wdata_l   <= 16'h0000;
         berr_l    <= 1'b0;
      end else if (clk_en) begin
         data_s1 <= mem_data_in;
         data_s2 <= data_s1;
         chk_s1  <= {upper_byte_check_bit_in, lower_byte_check_bit_in};
         chk_s2  <= chk_s1;
         ref_count <= ref_wrap ? 21'h000000 : ref_count + 21'h000001;
         ref_pend  <= ref_wrap | (ref_pend & ~take_ref);
         state <= next_state;
         timer <= next_timer;
         if (take_cpu) begin
            addr_l  <= cpu_addr;
            write_l <= cpu_write;
            ext_l   <= req_external;
            upper_l <= cpu_upper;
            lower_l <= cpu_lower;
            bank1_l <= ~hit[0];
            par_l   <= ~req_external & (hit[0] ? par_en[0] : par_en[1]);
            wdata_l <= cpu_wdata;
            berr_l  <= (hit == 2'b00) | ~req_user_ok;
         end else if (err_set != 2'b00) begin
            berr_l <= 1'b1;
         end
      end
   end

   // Registered pin and answer outputs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bank0_row_strobe_n      <= 1'b1;
         bank1_row_strobe_n      <= 1'b1;
         upper_byte_col_strobe_n <= 1'b1;
         lower_byte_col_strobe_n <= 1'b1;
         mem_write_strobe_n      <= 1'b1;
         row_col_select_out      <= 1'b0;
         mem_addr_out            <= 11'h000;
         mem_addr_oe             <= 1'b0;
         mem_data_out            <= 16'h0000;
         mem_data_oe             <= 1'b0;
         upper_byte_check_bit    <= 1'b0;
         lower_byte_check_bit    <= 1'b0;
         check_bits_oe           <= 1'b0;
         cpu_ack                 <= 1'b0;
         cpu_berr                <= 1'b0;
         cpu_rdata               <= 16'h0000;
      end else if (clk_en) begin
         bank0_row_strobe_n <= ~(((state == `DSPM_ST_ROW || state == `DSPM_ST_COL ||
            state == `DSPM_ST_CAS) && !bank1_l) ||
            (next_state == `DSPM_ST_RRAS && mem_config_reg[`DSPM_CFG_REF0]));
         bank1_row_strobe_n <= ~(((next_state == `DSPM_ST_ROW && !hit[0] && take_cpu) ||
            ((state == `DSPM_ST_ROW || state == `DSPM_ST_COL) && bank1_l) ||
            (next_state == `DSPM_ST_CAS && bank1_l)) ||
            (next_state == `DSPM_ST_RRAS && mem_config_reg[`DSPM_CFG_REF1]));
         if (next_state == `DSPM_ST_ROW && take_cpu && hit[0]) begin
            bank0_row_strobe_n <= 1'b0;
         end
         if (next_state == `DSPM_ST_DONE || next_state == `DSPM_ST_PRE) begin
            bank0_row_strobe_n <= 1'b1;
            bank1_row_strobe_n <= 1'b1;
         end
         upper_byte_col_strobe_n <= ~((next_state == `DSPM_ST_CAS && upper_l) ||
            next_state == `DSPM_ST_RCAS || next_state == `DSPM_ST_RRAS);
         lower_byte_col_strobe_n <= ~((next_state == `DSPM_ST_CAS && lower_l) ||
            next_state == `DSPM_ST_RCAS || next_state == `DSPM_ST_RRAS);
         mem_write_strobe_n <= ~(next_state == `DSPM_ST_CAS && write_l);
         row_col_select_out <= (next_state == `DSPM_ST_COL || next_state == `DSPM_ST_CAS);
         if (take_cpu) begin
            mem_addr_out <= {cpu_addr[22], cpu_addr[20], cpu_addr[18],
                             cpu_addr[16:9]};
            mem_addr_oe  <= ~req_external & (next_state == `DSPM_ST_ROW);
         end else if (next_state == `DSPM_ST_COL) begin
            mem_addr_out <= {addr_l[21], addr_l[19], addr_l[17],
                             addr_l[8:1]};
         end else if (next_state == `DSPM_ST_DONE || next_state == `DSPM_ST_IDLE) begin
            mem_addr_oe <= 1'b0;
         end
         mem_data_out <= wdata_l;
         mem_data_oe  <= (next_state == `DSPM_ST_COL || next_state == `DSPM_ST_CAS) &&
                         write_l && !ext_l;
         upper_byte_check_bit <= gen_bits[1];
         lower_byte_check_bit <= gen_bits[0];
         check_bits_oe <= (next_state == `DSPM_ST_COL || next_state == `DSPM_ST_CAS) &&
                          write_l && par_l;
         cpu_ack  <= (next_state == `DSPM_ST_DONE) && !berr_l && !(err_set != 2'b00) &&
                     !(take_cpu && ((hit == 2'b00) || !req_user_ok));
         cpu_berr <= (next_state == `DSPM_ST_DONE) && (berr_l || (err_set != 2'b00) ||
                     (take_cpu && ((hit == 2'b00) || !req_user_ok)));
         if (state == `DSPM_ST_CAS && timer == 8'h00 && !write_l) begin
            cpu_rdata <= data_s2;
         end
      end
   end

   // APB slave, zero wait states
   assign pready    = 1'b1;
   assign apb_setup = psel & ~penable;
   assign apb_wr    = psel & penable & pwrite & off_ok;
   assign off_ok    = (paddr == `DSPM_OFF_CONFIG) || (paddr == `DSPM_OFF_REFRESH) ||
                      (paddr == `DSPM_OFF_BASE0) || (paddr == `DSPM_OFF_BASE1) ||
                      (paddr == `DSPM_OFF_CHECK);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
         mem_config_reg           <= `DSPM_RST_CONFIG;
         refresh_interval_reg     <= `DSPM_RST_REFRESH;
         bank0_base_reg           <= `DSPM_RST_BASE;
         bank1_base_reg           <= `DSPM_RST_BASE;
         check_control_status_reg <= `DSPM_RST_CHECK;
      end else if (clk_en) begin
         if (apb_setup) begin
            pslverr <= ~off_ok;
            case (paddr)
               `DSPM_OFF_CONFIG:  prdata <= {16'h0000, mem_config_reg};
               `DSPM_OFF_REFRESH: prdata <= {16'h0000, refresh_interval_reg};
               `DSPM_OFF_BASE0:   prdata <= {16'h0000, bank0_base_reg};
               `DSPM_OFF_BASE1:   prdata <= {16'h0000, bank1_base_reg};
               `DSPM_OFF_CHECK:   prdata <= {16'h0000, check_control_status_reg};
               default:           prdata <= 32'h00000000;
            endcase
         end
         if (apb_wr && paddr == `DSPM_OFF_CONFIG) begin
            mem_config_reg <= pwdata[15:0];
         end
         if (apb_wr && paddr == `DSPM_OFF_REFRESH) begin
            refresh_interval_reg <= pwdata[15:0];
         end
         if (apb_wr && paddr == `DSPM_OFF_BASE0) begin
            bank0_base_reg <= pwdata[15:0];
         end
         if (apb_wr && paddr == `DSPM_OFF_BASE1) begin
            bank1_base_reg <= pwdata[15:0];
         end
         if (apb_wr && paddr == `DSPM_OFF_CHECK) begin
            check_control_status_reg[`DSPM_CHK_ODD] <= pwdata[`DSPM_CHK_ODD];
         end
         // Error flags: write one clears, a new error wins
         check_control_status_reg[`DSPM_CHK_ERR_HI:`DSPM_CHK_ERR_LO] <= err_set |
            (bank_check_error_flags &
             ~((apb_wr && paddr == `DSPM_OFF_CHECK) ?
               pwdata[`DSPM_CHK_ERR_HI:`DSPM_CHK_ERR_LO] : 2'b00));
      end
   end
endmodule

/* tb/dspm_ctrl_assertions.sv */
// Port checker for the DRAM strobe, parity and address mux controller
`timescale 1ns/100ps
module dspm_ctrl_assertions (
   // Clock and reset
   input wire        pclk,
   input wire        presetn,
   // Request side
   input wire        cpu_write,
   input wire        req_external,
   input wire [23:1] cpu_addr,
   input wire        cpu_ack,
   input wire        cpu_berr,
   // DRAM side
   input wire        bank0_row_strobe_n,
   input wire        bank1_row_strobe_n,
   input wire        upper_byte_col_strobe_n,
   input wire        lower_byte_col_strobe_n,
   input wire        mem_write_strobe_n,
   input wire        row_col_select_out,
   input wire [10:0] mem_addr_out,
   input wire        mem_addr_oe,
   input wire [15:0] mem_data_out,
   input wire        upper_byte_check_bit,
   input wire        lower_byte_check_bit,
   input wire        check_bits_oe,
   input wire        check_error_n
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   write_strobe_a: assert property (
      !mem_write_strobe_n |-> cpu_write && !(upper_byte_col_strobe_n && lower_byte_col_strobe_n))
      else $error("write strobe misplaced");
   row_first_a: assert property (
      $rose(row_col_select_out) |-> !$past(bank0_row_strobe_n) || !$past(bank1_row_strobe_n))
      else $error("no row strobe before column");
   cycle_end_a: assert property (
      $rose(row_col_select_out) |-> ##6 (cpu_ack || cpu_berr))
      else $error("access not answered");
   ack_after_col_a: assert property (
      $rose(cpu_ack) |-> !$past(upper_byte_col_strobe_n) || !$past(lower_byte_col_strobe_n))
      else $error("ack without column strobe");
   row_addr_a: assert property (
      ($fell(bank0_row_strobe_n) || $fell(bank1_row_strobe_n)) && upper_byte_col_strobe_n
      && mem_addr_oe |-> mem_addr_out == {cpu_addr[22], cpu_addr[20], cpu_addr[18], cpu_addr[16:9]})
      else $error("row address mapping wrong");
   col_addr_a: assert property (
      $rose(row_col_select_out) && mem_addr_oe
      |-> mem_addr_out == {cpu_addr[21], cpu_addr[19], cpu_addr[17], cpu_addr[8:1]})
      else $error("column address mapping wrong");
   ext_undriven_a: assert property (
      $rose(row_col_select_out) && req_external |-> !mem_addr_oe && !check_bits_oe)
      else $error("external cycle drives pins");
   check_gen_a: assert property (
      !mem_write_strobe_n && check_bits_oe |-> upper_byte_check_bit == ^mem_data_out[15:8]
      && lower_byte_check_bit == ^mem_data_out[7:0])
      else $error("generated check bits wrong");
   err_pin_a: assert property (
      $fell(check_error_n) |-> cpu_berr || $past(cpu_berr))
      else $error("error pin without bus error");
   cover property ($rose(cpu_berr));
   cover property ($rose(row_col_select_out) && req_external);
   cover property ($fell(lower_byte_col_strobe_n) && !row_col_select_out);
endmodule

bind dspm_ctrl dspm_ctrl_assertions chk (.*);

/* tb/dspm_dram_model.sv */
// Two-bank 16-bit DRAM with stored check bits
`timescale 1ns/100ps
module dspm_dram_model (
   // Clock and fault injection
   input  wire        pclk,
   input  wire        flip_upper,
   // Strobes and address
   input  wire        bank0_row_strobe_n,
   input  wire        bank1_row_strobe_n,
   input  wire        upper_byte_col_strobe_n,
   input  wire        lower_byte_col_strobe_n,
   input  wire        mem_write_strobe_n,
   input  wire        row_col_select_out,
   input  wire [10:0] mem_addr_out,
   // Data and check bits
   input  wire [15:0] mem_data_out,
   input  wire        upper_byte_check_bit,
   input  wire        lower_byte_check_bit,
   output wire [15:0] mem_data_in,
   output wire        upper_byte_check_bit_in,
   output wire        lower_byte_check_bit_in
);
   reg  [17:0] cells [0:131071];
   reg  [7:0]  row = 8'h00;
   reg  [7:0]  col = 8'h00;
   reg         bank = 1'b0;
   reg  [17:0] last = 18'h00000;
   wire [16:0] idx = {bank, row, col};
   wire        rd = mem_write_strobe_n && !(upper_byte_col_strobe_n && lower_byte_col_strobe_n);
   // Released bus shows inverse of last
   wire [17:0] word = rd ? cells[idx] ^ {flip_upper, 17'h00000} : ~last;
   assign {upper_byte_check_bit_in, lower_byte_check_bit_in, mem_data_in} = word;
   always @(posedge pclk) begin
      if (rd)
         last <= word;
      if (!row_col_select_out && upper_byte_col_strobe_n && lower_byte_col_strobe_n
          && !(bank0_row_strobe_n && bank1_row_strobe_n)) begin
         row <= mem_addr_out[7:0];
         bank <= !bank1_row_strobe_n;
      end
      if (row_col_select_out)
         col <= mem_addr_out[7:0];
      if (!mem_write_strobe_n && !upper_byte_col_strobe_n)
         {cells[idx][17], cells[idx][15:8]} <= {upper_byte_check_bit, mem_data_out[15:8]};
      if (!mem_write_strobe_n && !lower_byte_col_strobe_n)
         {cells[idx][16], cells[idx][7:0]} <= {lower_byte_check_bit, mem_data_out[7:0]};
   end
endmodule

/* tb/dram_strobe_parity_mux_tb_top.sv */
// Self-checking bench for the DRAM strobe, parity and address mux controller
`timescale 1ns/100ps
`include "dspm_defs.vh"
module dram_strobe_parity_mux_tb_top;
   localparam RB = 64;
   reg         pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, flip_upper = 1'b0;
   reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cpu_req = 1'b0, cpu_write = 1'b0;
   reg         cpu_supervisor = 1'b1, req_external = 1'b0, cpu_upper = 1'b0, cpu_lower = 1'b0;
   reg  [11:0] paddr = 12'h000;
   reg  [31:0] pwdata = 32'h0, q;
   reg  [23:1] cpu_addr = 23'h0;
   reg  [15:0] cpu_wdata = 16'h0, rdv;
   reg         bev, e;
   reg  [1:0]  bank_seen = 2'h0, lanes_seen = 2'h0;
   wire [31:0] prdata;
   wire [15:0] cpu_rdata, mem_data_in, mem_data_out;
   wire [10:0] mem_addr_out;
   wire        pready, pslverr, cpu_ack, cpu_berr, mem_addr_oe, mem_data_oe, check_bits_oe;
   wire        bank0_row_strobe_n, bank1_row_strobe_n, upper_byte_col_strobe_n;
   wire        lower_byte_col_strobe_n, mem_write_strobe_n, row_col_select_out, check_error_n;
   wire        upper_byte_check_bit_in, lower_byte_check_bit_in;
   wire        upper_byte_check_bit, lower_byte_check_bit;
   int         err_total = 0, num_checks = 0, cyc = 0, ref_last = 0, ref_gap = 0;

   dspm_ctrl #(.REFRESH_BASE(RB)) dut (.*);
   dspm_dram_model dram (.*);

   always #2.5 pclk = ~pclk;

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (row_col_select_out)
         bank_seen <= {!bank1_row_strobe_n, !bank0_row_strobe_n};
      if ($rose(cpu_req))
         lanes_seen <= 2'h0;
      else if (row_col_select_out)
         lanes_seen <= lanes_seen | {!upper_byte_col_strobe_n, !lower_byte_col_strobe_n};
      if ($fell(upper_byte_col_strobe_n) && !row_col_select_out && bank0_row_strobe_n) begin
         ref_gap <= cyc - ref_last;
         ref_last <= cyc;
      end
   end

   function [15:0] lane_mask(input [1:0] ln);
      lane_mask = {{8{ln[1]}}, {8{ln[0]}}};
   endfunction

   task conclude;
      if (err_total == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task check(input [31:0] seen, input [31:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %0s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task apb(input w, input [11:0] a, input [31:0] d);
      int n;
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
      {q, e} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   endtask

   task rd_chk(input [11:0] a, input [31:0] x, input string what);
      apb(1'b0, a, 32'h0);
      check(q, x, what);
   endtask

   task wr(input [11:0] a, input [31:0] d);
      apb(1'b1, a, d);
   endtask

   task cpu(input w, input ext, input sup, input [1:0] ln, input [23:1] a, input [15:0] d);
      int n;
      @(posedge pclk);
      {cpu_write, req_external, cpu_supervisor, cpu_upper, cpu_lower} <= {w, ext, sup, ln};
      cpu_addr <= a;
      cpu_wdata <= d;
      cpu_req <= 1'b1;
      n = 0;
      do @(negedge pclk); while (cpu_ack !== 1'b1 && cpu_berr !== 1'b1 && ++n < 300);
      check(32'(n < 300), 32'h1, "handshake");
      {rdv, bev} = {cpu_rdata, cpu_berr};
      @(posedge pclk);
      cpu_req <= 1'b0;
      repeat (14) @(posedge pclk);
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      err_total++;
      conclude;
   end

   initial begin
      int i, j, s;
      reg [1:0]  ln;
      reg [15:0] d, m [0:5];
      reg [23:1] a [0:5];
      reg        w;
      s = $urandom(32'h04A9);
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 6; i++) begin
         apb(1'b0, 12'(i * 4), 32'h0);
         check(q, 32'h0, "reset value");
         check(32'(e), 32'(i == 5), "slave error");
      end
      wr(`DSPM_OFF_CONFIG, 32'h0501);
      wr(`DSPM_OFF_BASE0, 32'h0081);
      wr(`DSPM_OFF_BASE1, 32'h8081);
      rd_chk(`DSPM_OFF_CONFIG, 32'h0501, "config");
      rd_chk(`DSPM_OFF_BASE1, 32'h8081, "base1");
      for (i = 0; i < 6; i++) begin
         a[i] = {i > 3, 6'($urandom), 13'($urandom), 3'(i)};
         m[i] = 16'h0000;
         cpu(1'b1, 1'b0, 1'b1, 2'h3, a[i], 16'h0000);
      end
      for (i = 0; i < 24; i++) begin
         j = $urandom_range(5);
         ln = 2'($urandom_range(3, 1));
         d = 16'($urandom);
         w = 1'($urandom_range(1));
         cpu(w, 1'b0, j > 3 ? 1'b1 : 1'($urandom_range(1)), ln, a[j], d);
         check(32'(bev), 32'h0, "bus error");
         check(32'(bank_seen), j > 3 ? 32'h2 : 32'h1, "row strobe");
         check(32'(lanes_seen), 32'(ln), "column strobes");
         if (w)
            m[j] = (m[j] & ~lane_mask(ln)) | (d & lane_mask(ln));
         else
            check(32'(rdv & lane_mask(ln)), 32'(m[j] & lane_mask(ln)), "read data");
      end
      cpu(1'b0, 1'b0, 1'b0, 2'h3, a[4], 16'h0000);
      check(32'(bev), 32'h1, "user access");
      flip_upper <= 1'b1;
      cpu(1'b0, 1'b0, 1'b1, 2'h1, a[0], 16'h0000);
      check(32'(bev), 32'h0, "lower lane error");
      cpu(1'b0, 1'b0, 1'b1, 2'h2, a[0], 16'h0000);
      check(32'(bev), 32'h1, "upper lane error");
      rd_chk(`DSPM_OFF_CHECK, 32'h0100, "error flags");
      check(32'(check_error_n), 32'h0, "error pin");
      wr(`DSPM_OFF_CHECK, 32'h0100);
      @(negedge pclk) check(32'(check_error_n), 32'h1, "error pin cleared");
      wr(`DSPM_OFF_CONFIG, 32'h0001);
      cpu(1'b0, 1'b0, 1'b1, 2'h3, a[0], 16'h0000);
      check(32'(bev), 32'h0, "parity off");
      wr(`DSPM_OFF_CONFIG, 32'h0501);
      cpu(1'b0, 1'b1, 1'b1, 2'h3, a[0], 16'h0000);
      check(32'(bev), 32'h0, "external read");
      rd_chk(`DSPM_OFF_CHECK, 32'h0, "external flags");
      flip_upper <= 1'b0;
      wr(`DSPM_OFF_BASE1, 32'h0);
      cpu(1'b0, 1'b0, 1'b1, 2'h3, a[5], 16'h0000);
      check(32'(bev), 32'h1, "disabled bank");
      for (i = 0; i < 2; i++) begin
         wr(`DSPM_OFF_REFRESH, 32'(i));
         repeat (4 * RB * (i + 1)) @(posedge pclk);
         check(ref_gap, RB * (i + 1), "refresh gap");
      end
      conclude;
   end
endmodule
